// ===== design/lsc_defs.vh
// Register offsets, field positions, reset values and divider counts
`ifndef LSC_DEFS_VH
`define LSC_DEFS_VH
`define LSC_ADDR_W        7
`define LSC_OFF_CTRL      7'h13
`define LSC_OFF_DUTY      7'h14
`define LSC_OFF_RAM_FIRST 7'h50
`define LSC_OFF_RAM_LAST  7'h6f
`define LSC_CTRL_SHOW     0
`define LSC_CTRL_PSW      1
`define LSC_CTRL_LOWPWR   2
`define LSC_CTRL_RESET    3'h0
`define LSC_DUTY_RESET    4'h0
`define LSC_DUTY_QUARTER  2'h0
`define LSC_DUTY_THIRD    2'h1
`define LSC_DUTY_HALF     2'h2
`define LSC_DUTY_STATIC   2'h3
`define LSC_SEL_SUB64     2'h0
`define LSC_SEL_SYS256    2'h1
`define LSC_SEL_SYS2048   2'h2
`define LSC_SEL_SPECIAL   2'h3
`define LSC_DIV_SUB       64
`define LSC_DIV_SYS_A     256
`define LSC_DIV_SYS_B     2048
`define LSC_DIV_SYS_SPEC  4096
`define LSC_DIV_SUB_SPEC  512
`define LSC_LAST_SUB      12'd63
`define LSC_LAST_SYS_A    12'd255
`define LSC_LAST_SYS_B    12'd2047
`define LSC_LAST_SYS_SPEC 12'd4095
`define LSC_LAST_SUB_SPEC 12'd511
`define LSC_NUM_SEG       32
`endif

// ===== design/lsc_tick_gen.v
// Reference tick generator: counts qualified source ticks
`timescale 1ns/1ps
`default_nettype none
module lsc_tick_gen (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        src_tick,
  input  wire [11:0] div_last,
  output reg         tick
);
  reg [11:0] cnt;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt  <= 12'h000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (src_tick) begin
        if (cnt >= div_last) begin
          cnt  <= 12'h000;
          tick <= 1'b1;
        end else begin
          cnt <= cnt + 12'h001;
        end
      end
    end
  end
endmodule // lsc_tick_gen
`default_nettype wire

// ===== design/lsc_lcd_ctrl.v
// Multiplexed LCD segment controller with dual-port display memory
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defs.vh"

module lsc_lcd_ctrl (
  input  wire                    clk,
  input  wire                    sys_rst,
  input  wire [`LSC_ADDR_W-1:0]  reg_addr,
  input  wire [3:0]              reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [3:0]              reg_rdata,
  input  wire                    sub_tick_pin,
  input  wire                    sys_div_tick,
  input  wire                    low_power_mode,
  input  wire                    timer_a_mode_bit3,
  output reg  [3:0]              com_active,
  output reg  [3:0]              com_phase,
  output reg  [`LSC_NUM_SEG-1:0] column_drive_line,
  output reg  [`LSC_NUM_SEG-1:0] column_phase,
  output reg                     power_switch_on,
  output reg                     top_bias_rail_at_supply,
  output reg                     outputs_grounded
);
  reg [2:0]  display_control_reg;
  reg [3:0]  duty_and_tick_reg;
  reg [3:0]  disp_mem [0:`LSC_NUM_SEG-1];
  reg        sub_meta;
  reg        sub_sync;
  reg        sub_prev;
  reg [1:0]  slot;
  reg        half_phase;
  reg [11:0] div_last;
  reg        src_tick;
  reg [`LSC_NUM_SEG-1:0] next_cols;
  reg [3:0]  next_com;
  wire       sub_tick;
  wire       lcd_tick;
  wire       ram_hit;
  wire [4:0] ram_idx;
  integer    i;
  integer    j;

  // Number of commons minus one for a duty code
  function [1:0] last_slot;
    input [1:0] duty;
    begin
      case (duty)
        `LSC_DUTY_QUARTER: last_slot = 2'h3;
        `LSC_DUTY_THIRD:   last_slot = 2'h2;
        `LSC_DUTY_HALF:    last_slot = 2'h1;
        default:           last_slot = 2'h0;
      endcase
    end
  endfunction

  // Subclock edge from a pin, synchronised
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sub_meta <= 1'b0;
      sub_sync <= 1'b0;
      sub_prev <= 1'b0;
    end else begin
      sub_meta <= sub_tick_pin;
      sub_sync <= sub_meta;
      sub_prev <= sub_sync;
    end
  end
  assign sub_tick = sub_sync & ~sub_prev;

  assign ram_hit = (reg_addr >= `LSC_OFF_RAM_FIRST) && (reg_addr <= `LSC_OFF_RAM_LAST);
  assign ram_idx = reg_addr[4:0] - 5'h10;

  // Register and memory writes; control registers are write-only
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      display_control_reg <= `LSC_CTRL_RESET;
      duty_and_tick_reg   <= `LSC_DUTY_RESET;
      reg_rdata           <= 4'h0;
      for (i = 0; i < `LSC_NUM_SEG; i = i + 1) begin
        disp_mem[i] <= 4'h0;
      end
    end else begin
      if (reg_wr) begin
        if (reg_addr == `LSC_OFF_CTRL) begin
          display_control_reg <= reg_wdata[2:0];
        end else if (reg_addr == `LSC_OFF_DUTY) begin
          duty_and_tick_reg <= reg_wdata;
        end else if (ram_hit) begin
          disp_mem[ram_idx] <= reg_wdata;
        end
      end
      if (reg_rd && ram_hit) begin
        reg_rdata <= disp_mem[ram_idx];
      end else begin
        reg_rdata <= 4'h0;
      end
    end
  end

  // Reference source and divide ratio selection
  always @* begin
    case (duty_and_tick_reg[3:2])
      `LSC_SEL_SUB64: begin
        src_tick = sub_tick;
        div_last = `LSC_LAST_SUB;
      end
      `LSC_SEL_SYS256: begin
        src_tick = sys_div_tick;
        div_last = `LSC_LAST_SYS_A;
      end
      `LSC_SEL_SYS2048: begin
        src_tick = sys_div_tick;
        div_last = `LSC_LAST_SYS_B;
      end
      default: begin
        // Special clock gets its duty factor from the frame counter below
        if (timer_a_mode_bit3) begin
          src_tick = sub_tick;
          div_last = `LSC_LAST_SUB_SPEC;
        end else begin
          src_tick = sys_div_tick;
          div_last = `LSC_LAST_SYS_SPEC;
        end
      end
    endcase
  end

  lsc_tick_gen u_tick (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .src_tick (src_tick),
    .div_last (div_last),
    .tick     (lcd_tick)
  );

  // Slot sequencing: each LCD tick is one slot, so frame = clock x duty
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot       <= 2'h0;
      half_phase <= 1'b0;
    end else if (lcd_tick) begin
      if (slot >= last_slot(duty_and_tick_reg[1:0])) begin
        slot       <= 2'h0;
        half_phase <= ~half_phase;
      end else begin
        slot <= slot + 2'h1;
      end
    end
  end

  // Segment data for the active common, read live from memory
  always @* begin
    next_com = 4'h0;
    next_com[slot] = 1'b1;
    for (j = 0; j < `LSC_NUM_SEG; j = j + 1) begin
      next_cols[j] = disp_mem[j][slot] & display_control_reg[`LSC_CTRL_SHOW];
    end
  end

  // Output drive registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      com_active              <= 4'h0;
      com_phase               <= 4'h0;
      column_drive_line       <= {`LSC_NUM_SEG{1'b0}};
      column_phase            <= {`LSC_NUM_SEG{1'b0}};
      power_switch_on         <= 1'b0;
      top_bias_rail_at_supply <= 1'b0;
      outputs_grounded        <= 1'b1;
    end else if (low_power_mode && !display_control_reg[`LSC_CTRL_LOWPWR]) begin
      com_active              <= 4'h0;
      com_phase               <= 4'h0;
      column_drive_line       <= {`LSC_NUM_SEG{1'b0}};
      column_phase            <= {`LSC_NUM_SEG{1'b0}};
      power_switch_on         <= 1'b0;
      top_bias_rail_at_supply <= 1'b0;
      outputs_grounded        <= 1'b1;
    end else begin
      com_active              <= next_com;
      com_phase               <= {4{half_phase}};
      column_drive_line       <= next_cols;
      column_phase            <= next_cols ^ {`LSC_NUM_SEG{half_phase}};
      power_switch_on         <= display_control_reg[`LSC_CTRL_PSW];
      top_bias_rail_at_supply <= display_control_reg[`LSC_CTRL_PSW];
      outputs_grounded        <= 1'b0;
    end
  end
endmodule // lsc_lcd_ctrl
`default_nettype wire

// ===== sim/lsc_sva.sv
// Port assertions for the LCD segment controller
`timescale 1ns/1ps
`default_nettype none
module lsc_sva (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_rdata,
  input wire logic [3:0]  com_active,
  input wire logic [3:0]  com_phase,
  input wire logic [31:0] column_drive_line,
  input wire logic [31:0] column_phase,
  input wire logic        power_switch_on,
  input wire logic        top_bias_rail_at_supply,
  input wire logic        outputs_grounded
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_bias_follows: assert property (
    top_bias_rail_at_supply == power_switch_on) else $error("bias rail off switch");
  a_ground_dark: assert property (
    outputs_grounded |-> com_active == 4'h0 && column_drive_line == 32'h0) else $error("lit");
  a_ground_open: assert property (
    outputs_grounded |-> !power_switch_on) else $error("switch closed while grounded");
  a_one_common: assert property (
    !outputs_grounded |-> $onehot(com_active)) else $error("not one common");
  a_col_polarity: assert property (
    column_phase == (column_drive_line ^ {32{com_phase[0]}})) else $error("column phase");
  a_phase_even: assert property (
    com_phase == 4'h0 || com_phase == 4'hf) else $error("uneven common phase");
  a_ctrl_reads_0: assert property (
    reg_rd && reg_addr == 7'h13 |=> reg_rdata == 4'h0) else $error("control readable");
  a_rdata_pulse: assert property (
    !reg_rd |=> reg_rdata == 4'h0) else $error("read data held");
endmodule // lsc_sva
`default_nettype wire

// ===== sim/lsc_panel_model.sv
// LCD panel model: keeps the segment pattern seen under each common
`timescale 1ns/1ps
`default_nettype none
module lsc_panel_model (
  input wire logic        clk,
  input wire logic [3:0]  com_active,
  input wire logic [31:0] column_drive_line
);
  logic [31:0] image [4];
  always @(posedge clk) begin
    for (int c = 0; c < 4; c++) begin
      if (com_active == (4'h1 << c)) begin
        image[c] <= column_drive_line;
      end
    end
  end
endmodule // lsc_panel_model
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the LCD segment controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, sub_tick_pin = 0;
  logic        sys_div_tick = 0, sys_run = 1, low_power_mode = 0, timer_a_mode_bit3 = 0;
  logic [6:0]  reg_addr = 0;
  logic [3:0]  reg_wdata = 0;
  logic [31:0] lfsr = 32'h9b24e60d, e;
  wire  [3:0]  reg_rdata, com_active, com_phase;
  wire  [31:0] column_drive_line, column_phase;
  wire         power_switch_on, top_bias_rail_at_supply, outputs_grounded;
  int          error_cnt = 0, n_compared = 0, cyc = 0, mem [32];
  time         t0;
  lsc_lcd_ctrl lsc_lcd_ctrl_i (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sub_tick_pin, .sys_div_tick, .low_power_mode, .timer_a_mode_bit3,
    .com_active, .com_phase, .column_drive_line, .column_phase, .power_switch_on,
    .top_bias_rail_at_supply, .outputs_grounded);
  lsc_panel_model lsc_panel_model_i (.clk, .com_active, .column_drive_line);
  always #20 clk = ~clk;
  // Subclock period 8 cycles, system divider tick every other cycle while sys_run is set
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sys_div_tick <= sys_run & ~sys_div_tick;
    if (cyc % 4 == 3) sub_tick_pin <= ~sub_tick_pin;
    if (cyc == 95000) begin
      error_cnt++;
      stop_test();
    end
  end
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [3:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [6:0] a, logic [3:0] x, string n);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(n, reg_rdata, x);
  endtask
  task automatic lvl(logic [3:0] c, logic g, logic s);
    wr(7'h13, c);
    repeat (3) @(posedge clk);
    #1 chk("grounded", outputs_grounded, g);
    chk("switch", power_switch_on, s);
  endtask
  // Frame length in cycles, from frame polarity toggles
  task automatic frame(logic [3:0] d, logic tma, int exp);
    @(posedge clk);
    timer_a_mode_bit3 <= tma;
    wr(7'h14, d);
    // Skip a toggle whose frame began under the old setting
    @(posedge clk);
    @(com_phase);
    t0 = $time;
    @(com_phase);
    chk("frame", ($time - t0) / 40, exp);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    rd(7'h13, 0, "ctrl_rd");
    rd(7'h14, 0, "duty_rd");
    wr(7'h20, 4'h5);
    rd(7'h20, 0, "unmapped_rd");
    @(posedge clk);
    low_power_mode <= 1;
    sys_run <= 0;
    lvl(4'h7, 0, 1);
    frame(4'h3, 0, 512);
    lvl(4'h3, 1, 0);
    @(posedge clk);
    low_power_mode <= 0;
    sys_run <= 1;
    lvl(4'h1, 0, 0);
    wr(7'h14, 4'h4);
    for (int k = 0; k < 32; k++) begin
      lfsr = nxt(lfsr);
      mem[k] = lfsr[3:0];
      wr(7'(7'h50 + k), lfsr[3:0]);
    end
    for (int k = 0; k < 32; k++) rd(7'(7'h50 + k), 4'(mem[k]), "mem_rd");
    repeat (4200) @(posedge clk);
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 32; k++) e[k] = mem[k][c];
      chk("image", lsc_panel_model_i.image[c], e);
    end
    lvl(4'h0, 0, 0);
    chk("blank", column_drive_line, 0);
    lvl(4'h2, 0, 1);
    $display("test registers and image done");
    for (int d = 0; d < 4; d++) frame(4'h4 | d, 0, (4 - d) * 512);
    frame(4'hf, 1, 4096);
    frame(4'hb, 0, 4096);
    frame(4'hf, 0, 8192);
    $display("test frames done");
    stop_test();
  end
endmodule // tb_top
bind lsc_lcd_ctrl lsc_sva lsc_sva_i (.clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata,
  .com_active, .com_phase, .column_drive_line, .column_phase, .power_switch_on,
  .top_bias_rail_at_supply, .outputs_grounded);
`default_nettype wire
